// file: hw/spl_pkg.sv
// Package for the byte-wide serial port: register map, fields, states.
// Assumes a single bus clock; pin inputs are asynchronous to it.
package spl_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] SPL_CTRL_OFS = 8'h10; // control_reg
  localparam logic [7:0] SPL_STAT_OFS = 8'h11; // status_control_reg
  localparam logic [7:0] SPL_DATA_OFS = 8'h12; // data_buffer_reg

  // control_reg field positions
  localparam int SPL_C_RXIE = 7; // Receive interrupt enable
  localparam int SPL_C_MSTR = 5; // master_select
  localparam int SPL_C_CLOCK_POLARITY_SELECT = 4; // clock_polarity_select
  localparam int SPL_C_CLOCK_PHASE_SELECT = 3; // clock_phase_select
  localparam int SPL_C_PEN  = 1; // port_enable

  // status_control_reg field positions
  localparam int SPL_S_RF   = 7; // receive_full_flag
  localparam int SPL_S_ERIE = 6; // error_irq_enable
  localparam int SPL_S_OVF  = 5; // overflow_flag
  localparam int SPL_S_MODE_FAULT_FLAG = 4; // mode_fault_flag
  localparam int SPL_S_TXE  = 3; // Transmit buffer empty
  localparam int SPL_S_MFE  = 2; // mode_fault_enable
  localparam int SPL_S_RATE = 0; // rate_divider_select, two bits

  // Transfer shape
  localparam logic [4:0] SPL_LAST_EDGE = 5'h10; // Sixteen clock edges
  localparam logic [4:0] SPL_FIRST_EDGE = 5'h01;
  localparam logic [4:0] SPL_SAMP1_MAX = 5'h02; // First sample edge bound

  // Transfer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } spl_state_e;

  // Pins coming in
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spl_pin_in_s;

  // Pins going out, each with its enable
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spl_pin_out_s;

  // Whole state of the port
  typedef struct packed {
    spl_state_e  st;
    logic        rx_irq_en;
    logic        master_select;
    logic        clock_polarity_select;
    logic        clock_phase_select;
    logic        port_enable;
    logic        error_irq_enable;
    logic        mode_fault_enable;
    logic [1:0]  rate_sel;
    logic        rf;
    logic        ovf;
    logic        mode_fault_flag;
    logic        tx_empty;
    logic        rf_arm;
    logic        ovf_arm;
    logic        mode_fault_flag_arm;
    logic        discard;
    logic [7:0]  txbuf;
    logic [7:0]  rxbuf;
    logic [7:0]  sh;
    logic [7:0]  rxs;
    logic [4:0]  edge_cnt;
    logic [6:0]  div_cnt;
    logic [2:0]  sck_s;
    logic [2:0]  ss_s;
    logic [2:0]  din_s;
    logic        sck_st;
    logic        ss_st;
    logic        din_st;
    logic        sck_o;
    logic        dout;
    logic        sck_oe;
    logic        mosi_oe;
    logic        miso_oe;
    logic        irq;
    logic [7:0]  rdata;
  } spl_state_s;

  // Value after reset: idle, buffer empty, select seen high
  localparam spl_state_s SPL_STATE_RST = '{
    st:       ST_IDLE,
    tx_empty: 1'b1,
    ss_s:     3'b111,
    ss_st:    1'b1,
    default:  '0
  };

endpackage : spl_pkg

// file: hw/spl_port.sv
// Byte-wide serial port, master or slave, with overflow and mode fault.
// Assumes one bus clock, pins resolved outside from the enables.
//
// Functional notes
// RL1: Slave drives MISO only while selected.
// RL2: Master's own select held high outside.
// RL3: Phase 1: first clock edge starts transfer.
// RL4: Phase 1: select may stay low between bytes.
// RL5: Phase 1 slave presents MSB at first edge.
// RL6: No shift-register load during a transfer.
// RL7: Slave software writes before first edge.
// RL8: Master data write starts a transfer.
// RL9: Phase sets first clock half of master; here either phase idles first.
// RL10: Master divider runs only when enabled master.
// RL11: Master clock edges on divider ticks.
// RL12: Start delay at most one bit time.
// RL13: Overflow at bit 1 keeps old byte.
// RL14: Overflow with error enable raises request.
// RL15: One enable gates overflow and mode fault.
// RL16: Mode fault never set while disabled.
// RL17: Select conflicting with mode sets mode fault.
// RL18: No receive-full request while overflow stands.
// RL19: Data read leaves late overflow set.
// RL20: Overflow request can wake the processor.
// RL21: Software enables overflow request or rereads.
// RL22: Status read then data read clears full.
// RL23: Clearing fault enable keeps fault flag.
// RL24: Rate bits select master divider.
// RL25: Eight bits each way, MSB first.
`timescale 1ns/10ps
`default_nettype none

module spl_port
  import spl_pkg::*;
(
  input  wire logic          ref_clk,  // Bus clock, 125 MHz
  input  wire logic          rstn,     // Synchronous reset, active low
  input  wire logic [7:0]    addr,     // Register offset
  input  wire logic [7:0]    wdata,    // Write data
  input  wire logic          wr,       // Write strobe
  input  wire logic          rd,       // Read strobe
  output logic [7:0]         rdata,    // Read data, cycle after strobe
  output logic               irq,      // Receiver/error request, also wake
  input  wire spl_pin_in_s   pin_i,    // Serial pins in
  output spl_pin_out_s       pin_o     // Serial pins out with enables
);

  spl_state_s r;        // Registered state
  spl_state_s n;        // Next state

  logic       mst;      // Enabled master
  logic       slv;      // Enabled slave
  logic [6:0] half_m1;  // Half bit time minus one
  logic [6:0] full_m1;  // Bit time minus one
  logic       tick;     // Master clock edge slot
  logic       tick_full;// Master bit boundary
  logic       ev;       // One clock edge to process
  logic       sck_edge; // Slave saw a clock edge
  logic       ss_fall;  // Slave saw select fall
  logic [4:0] k;        // Number of the edge in process
  logic       samp;     // This edge samples
  logic       shft;     // This edge shifts

  // Divider per rate bits: 2, 8, 32, 128 bus cycles per bit
  always_comb begin
    case (r.rate_sel)                                         // [RL24]
      2'b00:   half_m1 = 7'h00;
      2'b01:   half_m1 = 7'h03;
      2'b10:   half_m1 = 7'h0F;
      default: half_m1 = 7'h3F;
    endcase
    full_m1 = {half_m1[5:0], 1'b1};
  end

  // Next-state logic
  always_comb begin
    n = r;
    mst = r.port_enable & r.master_select;
    slv = r.port_enable & ~r.master_select;
    ev = 1'b0;
    k = r.edge_cnt + SPL_FIRST_EDGE;
    samp = 1'b0;
    shft = 1'b0;

    // Three-stage pin synchronisers, change counts when 2nd and 3rd agree
    n.sck_s = {r.sck_s[1:0], pin_i.sck};
    n.ss_s  = {r.ss_s[1:0], pin_i.ss_n};
    n.din_s = {r.din_s[1:0], r.master_select ? pin_i.miso : pin_i.mosi};
    if (r.sck_s[1] == r.sck_s[2]) begin
      n.sck_st = r.sck_s[2];
    end
    if (r.ss_s[1] == r.ss_s[2]) begin
      n.ss_st = r.ss_s[2];
    end
    if (r.din_s[1] == r.din_s[2]) begin
      n.din_st = r.din_s[2];
    end
    sck_edge = n.sck_st != r.sck_st;
    ss_fall = r.ss_st & ~n.ss_st;

    // Read data stands only in the cycle after the strobe
    n.rdata = 8'h00;
    if (rd) begin
      if (addr == SPL_CTRL_OFS) begin
        n.rdata[SPL_C_RXIE] = r.rx_irq_en;
        n.rdata[SPL_C_MSTR] = r.master_select;
        n.rdata[SPL_C_CLOCK_POLARITY_SELECT] = r.clock_polarity_select;
        n.rdata[SPL_C_CLOCK_PHASE_SELECT] = r.clock_phase_select;
        n.rdata[SPL_C_PEN]  = r.port_enable;
      end else if (addr == SPL_STAT_OFS) begin
        n.rdata[SPL_S_RF]   = r.rf;
        n.rdata[SPL_S_ERIE] = r.error_irq_enable;
        n.rdata[SPL_S_OVF]  = r.ovf;
        n.rdata[SPL_S_MODE_FAULT_FLAG] = r.mode_fault_flag;
        n.rdata[SPL_S_TXE]  = r.tx_empty;
        n.rdata[SPL_S_MFE]  = r.mode_fault_enable;
        n.rdata[SPL_S_RATE +: 2] = r.rate_sel;
        // Arm the flag clears with what software has now seen
        n.rf_arm   = r.rf;                                    // [RL22]
        n.ovf_arm  = r.ovf;                                   // [RL19]
        n.mode_fault_flag_arm = r.mode_fault_flag;
      end else if (addr == SPL_DATA_OFS) begin
        n.rdata = r.rxbuf;
        // Clear only flags seen set at the status read
        if (r.rf_arm) begin
          n.rf = 1'b0;                                        // [RL22]
        end
        if (r.ovf_arm) begin
          n.ovf = 1'b0;                                       // [RL19]
        end
        n.rf_arm = 1'b0;
        n.ovf_arm = 1'b0;
      end
    end

    // Register writes
    if (wr) begin
      if (addr == SPL_CTRL_OFS) begin
        n.rx_irq_en     = wdata[SPL_C_RXIE];
        n.master_select = wdata[SPL_C_MSTR];
        n.clock_polarity_select          = wdata[SPL_C_CLOCK_POLARITY_SELECT];
        n.clock_phase_select          = wdata[SPL_C_CLOCK_PHASE_SELECT];
        n.port_enable   = wdata[SPL_C_PEN];
        // Fault clears after status read, if no fault stands now
        if (r.mode_fault_flag_arm && !(mst && r.mode_fault_enable && !r.ss_st)) begin
          n.mode_fault_flag = 1'b0;
        end
        n.mode_fault_flag_arm = 1'b0;
      end else if (addr == SPL_STAT_OFS) begin
        n.error_irq_enable  = wdata[SPL_S_ERIE];
        n.mode_fault_enable = wdata[SPL_S_MFE];  // Flag kept [RL23]
        n.rate_sel          = wdata[SPL_S_RATE +: 2];
      end else if (addr == SPL_DATA_OFS) begin
        // Byte waits in the buffer; master starts on next bit slot
        n.txbuf = wdata;                                      // [RL8]
        n.tx_empty = 1'b0;                                    // [RL6]
      end
    end

    // Free-running master divider, stopped unless enabled master
    if (mst) begin
      n.div_cnt = r.div_cnt + 7'h01;                          // [RL10]
      // Wrap at the bit boundary
      if (r.div_cnt == full_m1) begin
        n.div_cnt = 7'h00;
      end
    end else begin
      n.div_cnt = 7'h00;                                      // [RL10]
    end
    tick_full = r.div_cnt == full_m1;
    tick = tick_full | (r.div_cnt == half_m1);                // [RL11]

    // Master sequencing
    if (mst) begin
      if (r.st == ST_IDLE) begin
        n.sck_o = r.clock_polarity_select;
        // Load at the next bit boundary: delay at most one bit time
        if (tick_full && !r.tx_empty) begin                   // [RL12]
          n.sh = r.txbuf;                                     // [RL8]
          n.dout = r.txbuf[7];                                // [RL25]
          n.tx_empty = 1'b1;
          n.st = ST_RUN;
          n.edge_cnt = 5'h00;
        end
      end else if (tick) begin
        // First edge half a bit after load; either phase idles first [RL9]
        ev = 1'b1;
      end
    end else if (slv) begin
      if (r.st == ST_IDLE) begin
        // Only an idle slave takes a new byte into its shifter
        if (!r.tx_empty) begin                                // [RL6]
          n.sh = r.txbuf;
          n.tx_empty = 1'b1;
        end
        n.dout = n.sh[7];                                     // [RL5]
        // Phase 1 starts on the first edge, select may stay low [RL4]
        if (!n.ss_st && (r.clock_phase_select ? sck_edge : ss_fall)) begin  // [RL3]
          n.st = ST_RUN;
          n.edge_cnt = 5'h00;
          ev = r.clock_phase_select;                                        // [RL5]
        end
      end else if (n.ss_st) begin
        // Deselected mid-transfer: abort, fault if allowed
        n.st = ST_IDLE;
        n.edge_cnt = 5'h00;
        n.discard = 1'b0;
        if (r.mode_fault_enable) begin                        // [RL16]
          n.mode_fault_flag = 1'b1;                                      // [RL17]
        end
      end else if (sck_edge) begin
        ev = 1'b1;
      end
    end

    // One clock edge of the transfer, common to both modes
    if (ev) begin
      n.edge_cnt = k;
      if (mst) begin
        n.sck_o = ~r.sck_o;                                   // [RL9]
      end
      samp = r.clock_phase_select ? ~k[0] : k[0];
      shft = r.clock_phase_select ? (k[0] && k != SPL_FIRST_EDGE)
                    : (~k[0] && k != SPL_LAST_EDGE);
      if (samp) begin
        n.rxs = {r.rxs[6:0], r.din_st};                       // [RL25]
        // Bit 1 captured while old byte unread: lose new byte
        if (k <= SPL_SAMP1_MAX && r.rf) begin
          n.ovf = 1'b1;                                       // [RL13]
          n.discard = 1'b1;                                   // [RL13]
        end
      end
      if (shft) begin
        n.sh = {r.sh[6:0], 1'b0};                             // [RL25]
        n.dout = r.sh[6];
      end
      if (k == SPL_LAST_EDGE) begin
        n.st = ST_IDLE;
        n.edge_cnt = 5'h00;
        // Discard decision was taken at the first sample edge
        if (!r.discard) begin
          n.rxbuf = n.rxs;                                    // [RL13]
          n.rf = 1'b1;
        end
        n.discard = 1'b0;
      end
    end

    // Master whose select goes low with fault enabled
    if (mst && r.mode_fault_enable && !n.ss_st) begin         // [RL16]
      n.mode_fault_flag = 1'b1;                                          // [RL17]
      n.port_enable = 1'b0;
    end

    // Disabled port: abort, empty transmit buffer and shifter; flags and receive side kept
    if (!n.port_enable) begin
      n.st = ST_IDLE;
      n.tx_empty = 1'b1;
      n.sh = 8'h00;
      n.edge_cnt = 5'h00;
      n.discard = 1'b0;
      n.sck_o = n.clock_polarity_select;
      n.dout = 1'b0;
    end

    // Pin enables; the master's own select is held high outside [RL2]
    n.sck_oe = n.port_enable & n.master_select;
    n.mosi_oe = n.port_enable & n.master_select;
    n.miso_oe = n.port_enable & ~n.master_select & ~n.ss_st;  // [RL1]

    // Shared request: one enable for both errors; full gated by overflow
    n.irq = (n.rx_irq_en & n.port_enable & n.rf & ~n.ovf)     // [RL18]
          | (n.error_irq_enable & (n.ovf | n.mode_fault_flag)); // [RL14] [RL15] [RL20]
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      r <= SPL_STATE_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign rdata = r.rdata;
  assign irq = r.irq;
  assign pin_o = '{sck_o:   r.sck_o,
                   sck_oe:  r.sck_oe,
                   mosi_o:  r.dout,
                   mosi_oe: r.mosi_oe,
                   miso_o:  r.dout,
                   miso_oe: r.miso_oe};

  // Checks on the port's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  miso_drive_a: assert property ( // [RL1]
    r.miso_oe |-> !r.ss_st && !r.master_select)
    else $error("MISO driven while deselected or master");

  start_delay_a: assert property ( // [RL12]
    (wr && addr == SPL_DATA_OFS && mst && r.st == ST_IDLE)
    |-> ##[1:129] (r.st == ST_RUN || !r.port_enable))
    else $error("Master transfer did not start within a bit time");

  sck_gate_a: assert property ( // [RL10]
    r.sck_oe |-> r.port_enable && r.master_select)
    else $error("Serial clock driven while not enabled master");

  ovf_keep_a: assert property ($rose(r.ovf) |-> $stable(r.rxbuf)) // [RL13]
    else $error("Unread byte overwritten on overflow");

  err_req_a: assert property (r.error_irq_enable && r.ovf |-> r.irq) // [RL14]
    else $error("Overflow with error enable gave no request");

  mode_fault_flag_gate_a: assert property ( // [RL16]
    !r.mode_fault_enable && !r.mode_fault_flag |=> !r.mode_fault_flag)
    else $error("Mode fault set while disabled");

  mode_fault_flag_hold_a: assert property ( // [RL23]
    $fell(r.mode_fault_enable) && $past(r.mode_fault_flag)
    && $past(addr) != SPL_CTRL_OFS |-> r.mode_fault_flag)
    else $error("Clearing fault enable cleared the flag");

  full_mute_a: assert property ( // [RL18]
    r.ovf && !r.error_irq_enable |-> !r.irq)
    else $error("Receive-full request while overflow stands");

  late_ovf_a: assert property ( // [RL19]
    rd && addr == SPL_DATA_OFS && !r.ovf_arm && r.ovf |=> r.ovf)
    else $error("Data read cleared an unseen overflow");

endmodule : spl_port

`default_nettype wire

// file: verification/spl_peer.sv
// Far-side slave model for the master port: phase 1, clock idle low.
// Assumes the bench resolves the wire and drives its select.
`timescale 1ns/10ps
`default_nettype none

module spl_peer (
  input  wire logic       sck,     // Clock seen on the wire
  input  wire logic       mosi,    // Master data
  input  wire logic       sel_n,   // Select, active low
  input  wire logic [7:0] tx_byte, // Byte for the next transfer
  output logic            miso,    // Slave data out
  output logic [7:0]      rx_byte  // Bits taken from the master
);
  logic [7:0] sh;  // Outgoing shifter
  int         cnt; // Edges seen in this byte

  // Quiet start
  initial begin
    cnt = 0;
    sh = '0;
    miso = 1'b0;
    rx_byte = '0;
  end

  // Leading edge: load on the first, shift out MSB first
  always @(posedge sck) begin
    if (!sel_n) begin
      if (cnt == 0) sh = tx_byte;
      miso = sh[7];
      sh = {sh[6:0], 1'b0};
      cnt++;
    end
  end

  // Trailing edge: sample; byte ends on edge 16, no reselect needed
  always @(negedge sck) begin
    if (!sel_n) begin
      rx_byte = {rx_byte[6:0], mosi};
      cnt = (cnt == 15) ? 0 : cnt + 1;
    end
  end

  // Released line shows the inverse of its last level
  always @(posedge sel_n) miso = ~miso;

endmodule : spl_peer
`default_nettype wire

// file: verification/spl_port_tb.sv
// Bench for the serial port: master traffic, overflow, faults, slave.
// Assumes spl_pkg, spl_port and spl_peer are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module spl_port_tb
  import spl_pkg::*;
;
  logic         ref_clk;    // Bus clock
  logic         rstn;       // Reset, active low
  logic [7:0]   addr;       // Register offset
  logic [7:0]   wdata;      // Write data
  logic         wr;         // Write strobe
  logic         rd;         // Read strobe
  logic [7:0]   rdata;      // Read data
  logic         irq;        // Request line
  spl_pin_in_s  pin_i;      // Resolved wire levels
  spl_pin_out_s pin_o;      // Design drivers
  logic         b_sck;      // Bench clock as master
  logic         b_mosi;     // Bench data as master
  logic         b_ss_n;     // Select into the design
  logic         p_sel_n;    // Peer select
  logic         p_miso;     // Peer data
  logic [7:0]   p_tx;       // Peer next byte
  logic [7:0]   p_rx;       // Peer received byte
  logic [7:0]   v, a, p;    // Scratch values
  int           num_errors; // Mismatches
  int           checks;     // Comparisons

  // Wire levels from every enable
  assign pin_i.sck  = pin_o.sck_oe ? pin_o.sck_o : b_sck;
  assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi_o : b_mosi;
  assign pin_i.miso = pin_o.miso_oe ? pin_o.miso_o : p_miso;
  assign pin_i.ss_n = b_ss_n;

  spl_port i_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .pin_i(pin_i), .pin_o(pin_o));

  spl_peer i_peer (.sck(pin_i.sck), .mosi(pin_i.mosi), .sel_n(p_sel_n),
    .tx_byte(p_tx), .miso(p_miso), .rx_byte(p_rx));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // One write cycle
  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= ofs;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // One read cycle, data taken in the cycle after
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= ofs;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Read and compare
  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp,
                      input string nm);
    rd_reg(ofs, v);
    chk(nm, v, exp);
  endtask : rchk

  // Master byte at rate r: start delay, bit time, idle level
  task automatic xfer(input logic [1:0] r, input logic [7:0] d,
                      input logic [7:0] q);
    int n;
    int e;
    int dv;
    dv = 2 << (2 * r);
    p_tx = q;
    wr_reg(SPL_DATA_OFS, d);
    n = 0;
    while (pin_o.sck_o !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("start_dly", 16'(n <= dv + dv / 2 + 2), 16'h1);
    e = 1;
    n = 0;
    while (e < 16 && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
      if (pin_o.sck_o !== 1'(e % 2)) e++;
    end
    chk("bit_time", 16'(n), 16'(15 * dv / 2));
    chk("sck_idle", pin_o.sck_o, 1'b0);
    if (e < 16) test_done;
    repeat (6) @(posedge ref_clk);
  endtask : xfer

  // Main sequence
  initial begin
    {rstn, addr, wdata, wr, rd, b_sck, b_mosi} = '0;
    {b_ss_n, p_sel_n, p_tx} = {2'b11, 8'h00};
    num_errors = 0;
    checks = 0;
    v = 8'($urandom(32'h0B6F));
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    p_sel_n <= 1'b0;
    // Reset state and an unmapped place
    rchk(SPL_STAT_OFS, 8'h08, "stat_rst");
    rchk(SPL_CTRL_OFS, 8'h00, "ctrl_rst");
    rchk(8'h13, 8'h00, "unmapped");
    chk("oe_rst", {pin_o.sck_oe, pin_o.miso_oe, irq}, 3'b000);
    // Master phase 1 at every rate
    wr_reg(SPL_CTRL_OFS, 8'h2A);
    for (int r = 0; r < 4; r++) begin
      wr_reg(SPL_STAT_OFS, 8'(r));
      a = (r == 3) ? 8'h80 : 8'($urandom);
      p = 8'($urandom);
      xfer(r[1:0], a, p);
      chk("peer_rx", p_rx, a);
      chk("miso_oe_m", pin_o.miso_oe, 1'b0);
      rchk(SPL_STAT_OFS, 8'h88 | 8'(r), "stat_full");
      rd_reg(SPL_DATA_OFS, v);
      if (r > 1) chk("rx_byte", v, p);
      rchk(SPL_STAT_OFS, 8'h08 | 8'(r), "stat_clr");
    end
    // Overflow with status read before it lands
    wr_reg(SPL_CTRL_OFS, 8'hAA);
    wr_reg(SPL_STAT_OFS, 8'h02);
    p = 8'($urandom);
    xfer(2'd2, 8'h5A, p);
    rchk(SPL_STAT_OFS, 8'h8A, "stat_b1");
    xfer(2'd2, 8'hA5, ~p);
    chk("irq_hold", irq, 1'b0);
    rchk(SPL_DATA_OFS, p, "rx_kept");
    rchk(SPL_STAT_OFS, 8'h2A, "ovf_left");
    wr_reg(SPL_STAT_OFS, 8'h42);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_ovf", irq, 1'b1);
    rchk(SPL_STAT_OFS, 8'h6A, "ovf_seen");
    rd_reg(SPL_DATA_OFS, v);
    rchk(SPL_STAT_OFS, 8'h4A, "ovf_clr");
    chk("irq_clr", irq, 1'b0);
    // Mode fault of a selected master
    wr_reg(SPL_CTRL_OFS, 8'h2A);
    wr_reg(SPL_STAT_OFS, 8'h40);
    @(posedge ref_clk);
    b_ss_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rchk(SPL_STAT_OFS, 8'h48, "no_fault");
    wr_reg(SPL_STAT_OFS, 8'h44);
    repeat (6) @(posedge ref_clk);
    #1 chk("irq_mf", irq, 1'b1);
    rchk(SPL_STAT_OFS, 8'h5C, "fault");
    rchk(SPL_CTRL_OFS, 8'h28, "pen_off");
    wr_reg(SPL_STAT_OFS, 8'h40);
    rchk(SPL_STAT_OFS, 8'h58, "fault_kept");
    @(posedge ref_clk);
    b_ss_n <= 1'b1;
    p_sel_n <= 1'b1;
    wr_reg(SPL_CTRL_OFS, 8'h0A);
    rchk(SPL_STAT_OFS, 8'h48, "fault_clr");
    // Slave phase 1, late write held back
    a = 8'($urandom);
    p = 8'($urandom);
    wr_reg(SPL_DATA_OFS, a);
    repeat (4) @(posedge ref_clk);
    #1 chk("miso_off", pin_o.miso_oe, 1'b0);
    @(posedge ref_clk);
    b_ss_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 chk("miso_on", pin_o.miso_oe, 1'b1);
    for (int e = 1; e <= 16; e++) begin
      @(posedge ref_clk);
      b_sck <= ~b_sck;
      if (e % 2 == 1) b_mosi <= p[7 - e / 2];
      repeat (6) @(posedge ref_clk);
      #1;
      if (e % 2) chk("sl_miso", pin_o.miso_o, a[7 - e / 2]);
      if (e == 1) wr_reg(SPL_DATA_OFS, ~a);
    end
    repeat (8) @(posedge ref_clk);
    rd_reg(SPL_STAT_OFS, v);
    chk("sl_full", v & 8'hF7, 8'hC0);
    rchk(SPL_DATA_OFS, p, "sl_rx");
    @(posedge ref_clk);
    b_ss_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 chk("miso_rel", pin_o.miso_oe, 1'b0);
    test_done;
  end

endmodule : spl_port_tb
`default_nettype wire
